// ---- mem_access_pointer_ctrl.sv ----
// Memory-access pointer, address extension and strobe timing registers
// Overview of operation
// - Code stores only with program write enable
// - Code writes use at least three wait states
// - Three upper-byte registers, reset to zero
// - Pointer moves take upper byte from extension
// - Indirect moves use indirect byte, port two
// - Select bit picks pointer; pointers reset zero
// - Direction bit turns increment into decrement
// - Toggle enable inverts select on pointer ops other than jump
// - Toggle clear leaves select bit unchanged
// - Selected pointer serves all pointer instructions
// - Strobe width equals field plus one, never below three
// - Strobe field resets to slowest setting
// - New strobe width applies to next move
// - Stack pointer pre-increments, post-decrements, resets seven
// - Reboot bit maps application entry region
// - ISP enabled when disable bit clear
// - Busy flag read-only; full flash reads zero
// - Boot flag shows boot code running
module mem_access_pointer_ctrl
  import mem_access_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Special function register port
  input wire logic sfrWrite,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  output logic sfrHit,
  // Core requests
  input wire mem_access_pkg::ptr_op_t ptrOp,
  input wire logic [15:0] loadValue,
  input wire logic [7:0] accValue,
  input wire logic useIndirect,
  input wire logic [7:0] indirectLow,
  input wire logic [7:0] portTwoRegister,
  input wire logic [7:0] writeData,
  input wire logic programWriteEnable,
  input wire mem_access_pkg::stack_op_t stackOp,
  // Flash status
  input wire logic flashBusyFlag,
  input wire logic bootRunningFlag,
  // Memory side
  output logic [23:0] memAddr,
  output logic [7:0] memWdata,
  output logic dataReadStrobe,
  output logic dataWriteStrobe,
  output logic codeWriteStrobe,
  output logic accessBusy,
  output logic [15:0] activePointer,
  output logic appEntryEnable,
  output logic ispEnable,
  output logic [7:0] stackPointer
);
  import mem_access_pkg::*;

  logic [7:0] stack_pointer_r;
  logic [15:0] ptr0_r, ptr1_r;
  logic [7:0] pointer_select_r, strobe_width_control_r;
  logic [7:0] ptr0Upper_r, ptr1Upper_r, indirectUpper_r;
  logic reboot_r, ispDis_r;
  logic busySync1_r, busySync_r, bootSync1_r, bootSync_r;

  typedef enum logic [1:0] {IDLE, STROBE, HOLD} move_state_t;
  move_state_t state_r;
  logic [3:0] count_r;
  logic isWrite_r, isCode_r;
  logic [23:0] addr_r;
  logic [7:0] wdata_r;

  logic sel;
  logic startMove;
  logic [2:0] field;
  logic [3:0] pulseLen;

  assign sel = pointer_select_r[SEL_BIT];
  assign activePointer = sel ? ptr1_r : ptr0_r;
  assign startMove = (state_r == IDLE) &&
                     (ptrOp == OP_XREAD || ptrOp == OP_XWRITE);
  assign field = strobe_width_control_r[STROBE_MSB:STROBE_LSB];

  // Unused field codes fall back to the shortest legal width
  function automatic logic [3:0] width_of(input logic [2:0] f);
    logic [2:0] g;
    g = (f < STROBE_MIN_FIELD) ? STROBE_MIN_FIELD : f;
    return {1'b0, g} + 4'h1;
  endfunction

  always_comb begin
    pulseLen = width_of(field);
    // Code stores need three wait states, so four strobe clocks minimum
    if (programWriteEnable && ptrOp == OP_XWRITE &&
        pulseLen < CODE_WAIT_MIN + 4'h1) begin
      pulseLen = CODE_WAIT_MIN + 4'h1;
    end
  end

  // Flash status levels come from another block; synchronise them
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      busySync1_r <= 1'b0;
      busySync_r <= 1'b0;
      bootSync1_r <= 1'b0;
      bootSync_r <= 1'b0;
    end else begin
      busySync1_r <= flashBusyFlag;
      busySync_r <= busySync1_r;
      bootSync1_r <= bootRunningFlag;
      bootSync_r <= bootSync1_r;
    end
  end

  // Stack pointer: software write wins over push and pop
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stack_pointer_r <= RST_STACK_POINTER;
    end else if (sfrWrite && sfrAddr == ADDR_STACK_POINTER) begin
      stack_pointer_r <= sfrWdata;
    end else if (stackOp == SP_PUSH) begin
      stack_pointer_r <= stack_pointer_r + 8'h01;
    end else if (stackOp == SP_POP) begin
      stack_pointer_r <= stack_pointer_r - 8'h01;
    end
  end
  assign stackPointer = stack_pointer_r;
  AST_PUSH_INC: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    stackOp == SP_PUSH && !sfrWrite |=>
      stack_pointer_r == $past(stack_pointer_r) + 8'h01)
    else $error("push did not increment");

  // Data pointers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ptr0_r <= RST_POINTER;
      ptr1_r <= RST_POINTER;
    end else begin
      if (sfrWrite && sfrAddr == ADDR_PTR0_LOW) ptr0_r[7:0] <= sfrWdata;
      if (sfrWrite && sfrAddr == ADDR_PTR0_HIGH) ptr0_r[15:8] <= sfrWdata;
      if (sfrWrite && sfrAddr == ADDR_PTR1_LOW) ptr1_r[7:0] <= sfrWdata;
      if (sfrWrite && sfrAddr == ADDR_PTR1_HIGH) ptr1_r[15:8] <= sfrWdata;
      if (ptrOp == OP_LOAD) begin
        if (sel) ptr1_r <= loadValue;
        else ptr0_r <= loadValue;
      end else if (ptrOp == OP_INC) begin
        if (sel) begin
          ptr1_r <= pointer_select_r[DIR1_BIT] ? ptr1_r - 16'h0001
                                               : ptr1_r + 16'h0001;
        end else begin
          ptr0_r <= pointer_select_r[DIR0_BIT] ? ptr0_r - 16'h0001
                                               : ptr0_r + 16'h0001;
        end
      end
    end
  end

  // Pointer select; jump does not toggle the select bit
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pointer_select_r <= RST_BYTE_ZERO;
    end else if (sfrWrite && sfrAddr == ADDR_POINTER_SELECT) begin
      pointer_select_r <= sfrWdata & 8'hE1;
    end else if (pointer_select_r[TOGGLE_BIT] &&
                 (ptrOp == OP_INC || ptrOp == OP_LOAD ||
                  ptrOp == OP_CODE_READ || ptrOp == OP_XREAD ||
                  ptrOp == OP_XWRITE)) begin
      pointer_select_r[SEL_BIT] <= ~sel;
    end
  end

  AST_RESET_VALUES: assert property (
    @(posedge sys_clk) !reset_n |=> stack_pointer_r == RST_STACK_POINTER
      && ptr0_r == RST_POINTER && field == RST_STROBE_FIELD
      && ptr0Upper_r == RST_BYTE_ZERO)
    else $error("reset values wrong");
  AST_TOGGLE: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    pointer_select_r[TOGGLE_BIT] && ptrOp == OP_INC && !sfrWrite |=>
      sel != $past(sel))
    else $error("select not toggled");
  AST_NO_TOGGLE: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !pointer_select_r[TOGGLE_BIT] && !sfrWrite |=> $stable(sel))
    else $error("select changed");
  AST_DEC_DIR: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ptrOp == OP_INC && !sel && pointer_select_r[DIR0_BIT] && !sfrWrite
      |=> ptr0_r == $past(ptr0_r) - 16'h0001)
    else $error("direction ignored");

  // Strobe width control and upper-byte extension registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      strobe_width_control_r <= {5'h00, RST_STROBE_FIELD};
      ptr0Upper_r <= RST_BYTE_ZERO;
      ptr1Upper_r <= RST_BYTE_ZERO;
      indirectUpper_r <= RST_BYTE_ZERO;
    end else if (sfrWrite) begin
      if (sfrAddr == ADDR_STROBE_WIDTH) begin
        strobe_width_control_r <= sfrWdata & 8'hC7;
      end
      if (sfrAddr == ADDR_PTR0_UPPER) ptr0Upper_r <= sfrWdata;
      if (sfrAddr == ADDR_PTR1_UPPER) ptr1Upper_r <= sfrWdata;
      if (sfrAddr == ADDR_INDIRECT_UPPER) indirectUpper_r <= sfrWdata;
    end
  end

  // Boot configuration: reserved bits are not stored
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reboot_r <= 1'b0;
      ispDis_r <= 1'b0;
    end else if (sfrWrite && sfrAddr == ADDR_BOOT_CONFIG) begin
      reboot_r <= sfrWdata[REBOOT_BIT];
      ispDis_r <= sfrWdata[ISP_DIS_BIT];
    end
  end
  assign appEntryEnable = reboot_r;
  assign ispEnable = ~ispDis_r;

  // External move sequencer: strobe then one hold clock
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_r <= IDLE;
      count_r <= 4'h0;
      isWrite_r <= 1'b0;
      isCode_r <= 1'b0;
      addr_r <= 24'h000000;
      wdata_r <= 8'h00;
    end else begin
      unique case (state_r)
        IDLE: begin
          if (startMove) begin
            state_r <= STROBE;
            count_r <= pulseLen - 4'h1;
            isWrite_r <= (ptrOp == OP_XWRITE);
            isCode_r <= (ptrOp == OP_XWRITE) && programWriteEnable;
            wdata_r <= writeData;
            if (useIndirect) begin
              addr_r <= {indirectUpper_r, portTwoRegister,
                         indirectLow};
            end else begin
              addr_r <= sel ? {ptr1Upper_r, ptr1_r}
                            : {ptr0Upper_r, ptr0_r};
            end
          end
        end
        STROBE: begin
          if (count_r == 4'h0) state_r <= HOLD;
          else count_r <= count_r - 4'h1;
        end
        HOLD: begin
          state_r <= IDLE;
        end
      endcase
    end
  end

  assign memAddr = addr_r;
  assign memWdata = wdata_r;
  assign dataReadStrobe = (state_r == STROBE) && !isWrite_r;
  assign dataWriteStrobe = (state_r == STROBE) && isWrite_r && !isCode_r;
  assign codeWriteStrobe = (state_r == STROBE) && isCode_r;
  assign accessBusy = (state_r != IDLE);
  AST_UPPER0: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    startMove && !useIndirect && !sel |=>
      memAddr[23:16] == $past(ptr0Upper_r))
    else $error("upper byte wrong");
  AST_INDIRECT: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    startMove && useIndirect |=>
      memAddr[15:8] == $past(portTwoRegister)
      && memAddr[23:16] == $past(indirectUpper_r))
    else $error("indirect address wrong");
  AST_STROBE_LEN: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    startMove && ptrOp == OP_XREAD && field == STROBE_MIN_FIELD |=>
      dataReadStrobe [*3] ##1 !dataReadStrobe)
    else $error("strobe width wrong");
  AST_CODE_HOLD: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $fell(codeWriteStrobe) |-> $stable(memAddr) && $stable(memWdata)
      && accessBusy)
    else $error("code hold broken");
  AST_CODE_MIN: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(codeWriteStrobe) |-> codeWriteStrobe [*4])
    else $error("code write too short");

  // Register read mux
  always_comb begin
    sfrHit = 1'b1;
    unique case (sfrAddr)
      ADDR_STACK_POINTER: sfrRdata = stack_pointer_r;
      ADDR_PTR0_LOW: sfrRdata = ptr0_r[7:0];
      ADDR_PTR0_HIGH: sfrRdata = ptr0_r[15:8];
      ADDR_PTR1_LOW: sfrRdata = ptr1_r[7:0];
      ADDR_PTR1_HIGH: sfrRdata = ptr1_r[15:8];
      ADDR_POINTER_SELECT: sfrRdata = pointer_select_r;
      ADDR_STROBE_WIDTH: sfrRdata = strobe_width_control_r;
      ADDR_PTR0_UPPER: sfrRdata = ptr0Upper_r;
      ADDR_PTR1_UPPER: sfrRdata = ptr1Upper_r;
      ADDR_INDIRECT_UPPER: sfrRdata = indirectUpper_r;
      ADDR_BOOT_CONFIG: sfrRdata = {reboot_r, ispDis_r, 3'h0, 1'b0,
        busySync_r, bootSync_r};
      default: begin
        sfrRdata = 8'h00;
        sfrHit = 1'b0;
      end
    endcase
  end

endmodule

// ---- mem_access_pkg.sv ----
// Register map, field positions and timing constants for memory-access block
package mem_access_pkg;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADDR_PTR0_LOW = 8'h82;
  localparam logic [7:0] ADDR_PTR0_HIGH = 8'h83;
  localparam logic [7:0] ADDR_PTR1_LOW = 8'h84;
  localparam logic [7:0] ADDR_PTR1_HIGH = 8'h85;
  localparam logic [7:0] ADDR_POINTER_SELECT = 8'h86;
  localparam logic [7:0] ADDR_STROBE_WIDTH = 8'h8E;
  localparam logic [7:0] ADDR_PTR0_UPPER = 8'h93;
  localparam logic [7:0] ADDR_PTR1_UPPER = 8'h95;
  localparam logic [7:0] ADDR_INDIRECT_UPPER = 8'hEA;
  localparam logic [7:0] ADDR_BOOT_CONFIG = 8'hFF;

  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [15:0] RST_POINTER = 16'h0000;
  localparam logic [7:0] RST_BYTE_ZERO = 8'h00;
  localparam logic [2:0] RST_STROBE_FIELD = 3'h7;

  // Pointer select fields
  localparam int SEL_BIT = 0;
  localparam int TOGGLE_BIT = 5;
  localparam int DIR0_BIT = 6;
  localparam int DIR1_BIT = 7;
  // Strobe control fields
  localparam int STROBE_LSB = 0;
  localparam int STROBE_MSB = 2;
  localparam int WD_LSB = 6;
  localparam int WD_MSB = 7;
  // Boot config fields
  localparam int REBOOT_BIT = 7;
  localparam int ISP_DIS_BIT = 6;
  localparam int FULL_FLASH_BIT = 2;
  localparam int BUSY_BIT = 1;
  localparam int BOOT_RUN_BIT = 0;

  localparam logic [2:0] STROBE_MIN_FIELD = 3'h2;
  localparam logic [3:0] CODE_WAIT_MIN = 4'h3;
  localparam logic [15:0] APP_ENTRY_LOW = 16'hFFF7;
  localparam logic [15:0] APP_ENTRY_HIGH = 16'hFFFF;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_INC,
    OP_LOAD,
    OP_CODE_READ,
    OP_JUMP,
    OP_XREAD,
    OP_XWRITE
  } ptr_op_t;

  typedef enum logic [1:0] {
    SP_HOLD,
    SP_PUSH,
    SP_POP
  } stack_op_t;
endpackage

// ---- ext_mem_model.sv ----
// Behavioural slow memory that times and watches the move strobes
module ext_mem_model (
  // Clock
  input wire logic sys_clk,
  // Move side
  input wire logic [23:0] memAddr,
  input wire logic [7:0] memWdata,
  input wire logic dataReadStrobe,
  input wire logic dataWriteStrobe,
  input wire logic codeWriteStrobe,
  // Observations
  output logic [3:0] width,
  output logic [2:0] kind,
  output logic stableErr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] strobes;
  logic [2:0] prevStrobes;
  logic [23:0] addrSeen;
  logic [7:0] dataSeen;
  assign strobes = {codeWriteStrobe, dataWriteStrobe, dataReadStrobe};
  initial begin
    width = 4'h0;
    kind = 3'h0;
    stableErr = 1'b0;
    prevStrobes = 3'h0;
  end
  // A slow device latches at the strobe edges, so any drift is a fault
  always @(posedge sys_clk) begin
    prevStrobes <= strobes;
    if (strobes != 3'h0 && prevStrobes == 3'h0) begin
      width <= 4'h1;
      kind <= strobes;
      addrSeen <= memAddr;
      dataSeen <= memWdata;
    end else if (strobes != 3'h0) begin
      width <= width + 4'h1;
      if (memAddr !== addrSeen || memWdata !== dataSeen) begin
        stableErr <= 1'b1;
      end
    end else if (prevStrobes != 3'h0 && memWdata !== dataSeen) begin
      stableErr <= 1'b1;
    end
  end
endmodule

// ---- mem_access_pointer_ctrl_test.sv ----
// Self-checking bench for the memory-access pointer block
module mem_access_pointer_ctrl_test;
  import mem_access_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset_n, sfrWrite, sfrHit, useIndirect;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, accValue, indirectLow;
  logic [7:0] portTwoRegister, writeData, memWdata, stackPointer;
  logic programWriteEnable, flashBusyFlag, bootRunningFlag;
  logic dataReadStrobe, dataWriteStrobe, codeWriteStrobe, accessBusy;
  logic appEntryEnable, ispEnable, stableErr;
  logic [15:0] loadValue, activePointer, seed, p0, p1;
  logic [23:0] memAddr;
  logic [3:0] width;
  logic [2:0] kind;
  logic [7:0] u0, u1, ux, sel;
  ptr_op_t ptrOp;
  stack_op_t stackOp;
  int errCount, comparisons, cycles;
  logic [7:0] regA [11] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86,
    8'h8E, 8'h93, 8'h95, 8'hEA, 8'hFF};
  logic [7:0] regR [11] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
  ptr_op_t ops [6] = '{OP_INC, OP_LOAD, OP_CODE_READ, OP_JUMP, OP_XREAD,
    OP_XWRITE};

  mem_access_pointer_ctrl i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .sfrWrite(sfrWrite), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .sfrHit(sfrHit), .ptrOp(ptrOp),
    .loadValue(loadValue), .accValue(accValue), .useIndirect(useIndirect),
    .indirectLow(indirectLow), .portTwoRegister(portTwoRegister),
    .writeData(writeData), .programWriteEnable(programWriteEnable),
    .stackOp(stackOp), .flashBusyFlag(flashBusyFlag),
    .bootRunningFlag(bootRunningFlag), .memAddr(memAddr),
    .memWdata(memWdata), .dataReadStrobe(dataReadStrobe),
    .dataWriteStrobe(dataWriteStrobe), .codeWriteStrobe(codeWriteStrobe),
    .accessBusy(accessBusy), .activePointer(activePointer),
    .appEntryEnable(appEntryEnable), .ispEnable(ispEnable),
    .stackPointer(stackPointer));
  ext_mem_model i_mem (.sys_clk(sys_clk), .memAddr(memAddr),
    .memWdata(memWdata), .dataReadStrobe(dataReadStrobe),
    .dataWriteStrobe(dataWriteStrobe), .codeWriteStrobe(codeWriteStrobe),
    .width(width), .kind(kind), .stableErr(stableErr));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Unused field codes behave as the shortest legal width of three
  function automatic logic [23:0] exp_width(input int f);
    return (f < 2) ? 24'h3 : 24'(f + 1);
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errCount++;
      end_of_test();
    end
  end
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [23:0] e,
      input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Strobe is dropped then a cycle passes, so back-to-back calls stay clean
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrWrite = 1'b1;
    sfrAddr = a;
    sfrWdata = d;
    tick();
    sfrWrite = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfrAddr = a;
    tick();
    chk($sformatf("reg %h", a), 24'(e), 24'(sfrRdata));
  endtask
  task automatic op(input ptr_op_t o);
    int i;
    ptrOp = o;
    tick();
    ptrOp = OP_NONE;
    tick();
    for (i = 0; i < 20 && accessBusy === 1'b1; i++) tick();
  endtask
  task automatic stk(input stack_op_t s, input logic [7:0] e);
    stackOp = s;
    tick();
    stackOp = SP_HOLD;
    tick();
    chk("stack", 24'(e), 24'(stackPointer));
  endtask

  initial begin
    {sfrWrite, sfrAddr, sfrWdata, loadValue, accValue} = '0;
    {useIndirect, indirectLow, portTwoRegister, writeData} = '0;
    {programWriteEnable, flashBusyFlag, bootRunningFlag} = '0;
    ptrOp = OP_NONE;
    stackOp = SP_HOLD;
    seed = 16'h8DFA;
    reset_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    foreach (regA[i]) rd(regA[i], regR[i]);
    chk("hit mapped", 24'h1, 24'(sfrHit));
    chk("isp", 24'h1, 24'(ispEnable));
    chk("entry", 24'h0, 24'(appEntryEnable));
    wr(8'h80, 8'h5A);
    rd(8'h80, 8'h00);
    chk("hit", 24'h0, 24'(sfrHit));
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed); u0 = seed[7:0]; p0 = lfsr(seed); seed = p0;
      wr(8'h93, u0);
      wr(8'h82, p0[7:0]);
      wr(8'h83, p0[15:8]);
      wr(8'h86, 8'h00);
      rd(8'h83, p0[15:8]);
      op(OP_XREAD);
      chk("addr0", {u0, p0}, memAddr);
      seed = lfsr(seed); u1 = seed[7:0]; p1 = lfsr(seed); seed = p1;
      wr(8'h86, 8'h01);
      wr(8'h95, u1);
      loadValue = p1;
      op(OP_LOAD);
      writeData = u0 ^ u1;
      op(OP_XWRITE);
      chk("addr1", {u1, p1}, memAddr);
      chk("wdata", 24'(u0 ^ u1), 24'(memWdata));
      chk("kind", 24'h2, 24'(kind));
      seed = lfsr(seed); ux = seed[7:0];
      wr(8'hEA, ux);
      {portTwoRegister, indirectLow} = lfsr(seed);
      useIndirect = 1'b1;
      op(OP_XREAD);
      useIndirect = 1'b0;
      chk("addrx", {ux, portTwoRegister, indirectLow}, memAddr);
    end
    $display("test addressing done");
    for (int f = 0; f < 8; f++) begin
      wr(8'h8E, 8'(f));
      rd(8'h8E, 8'(f));
      op(OP_XREAD);
      chk("width", exp_width(f), 24'(width));
    end
    programWriteEnable = 1'b1;
    wr(8'h8E, 8'h02);
    op(OP_XWRITE);
    programWriteEnable = 1'b0;
    chk("code kind", 24'h4, 24'(kind));
    chk("code width", 24'h1, 24'(width >= 4'h4));
    chk("stable", 24'h0, 24'(stableErr));
    $display("test strobes done");
    wr(8'h86, 8'h40);
    wr(8'h82, 8'h00);
    wr(8'h83, 8'h00);
    op(OP_INC);
    chk("dec0", 24'hFFFF, 24'(activePointer));
    wr(8'h86, 8'h41);
    op(OP_INC);
    chk("inc1", 24'(16'(p1 + 16'h1)), 24'(activePointer));
    wr(8'h86, 8'hC1);
    op(OP_INC);
    chk("dec1", 24'(p1), 24'(activePointer));
    for (int t = 1; t >= 0; t--) begin
      sel = 8'(t) << 5;
      wr(8'h86, sel);
      foreach (ops[i]) begin
        op(ops[i]);
        if (t == 1 && ops[i] != OP_JUMP) sel[0] = ~sel[0];
        rd(8'h86, sel);
      end
    end
    $display("test pointers done");
    wr(8'h81, 8'hFE);
    stk(SP_PUSH, 8'hFF);
    stk(SP_PUSH, 8'h00);
    stk(SP_POP, 8'hFF);
    rd(8'h81, 8'hFF);
    wr(8'hFF, 8'hC0);
    rd(8'hFF, 8'hC0);
    chk("entry", 24'h1, 24'(appEntryEnable));
    chk("isp", 24'h0, 24'(ispEnable));
    {flashBusyFlag, bootRunningFlag} = 2'b11;
    repeat (3) tick();
    rd(8'hFF, 8'hC3);
    wr(8'hFF, 8'h00);
    {flashBusyFlag, bootRunningFlag} = 2'b01;
    repeat (3) tick();
    rd(8'hFF, 8'h01);
    chk("isp", 24'h1, 24'(ispEnable));
    $display("test stack and boot done");
    end_of_test();
  end
endmodule
